// ### hw/pport_device.sv
// Behaviour
// [RULE1] separate read/write strobes, dedicated or latched address
// [RULE2] common strobe with read/write select line
// [RULE3] handshake mode: multiplexed bus with wait answer
// [RULE4] address on low six lines, data eight
// [RULE5] latch enable high latches the address
// [RULE6] address strobe high latches in common mode
// [RULE7] handshake address strobe low latches address
// [RULE8] wait low starts, high ends access
// [RULE9] three address lines map to bits 0-2
// [RULE10] eight-bit two-way data bus, dedicated mode
// [RULE11] multiplexed lines carry address then data
// [RULE12] spi: latch pin select, line2 clock, line0 data
// [RULE13] spi: data line zero is serial output
// [RULE14] powerdown high: oscillator off, pins ignored
// [RULE15] powerdown falling edge starts internal reset
// [RULE16] every reset clears mode, detects again
// [RULE17] mode from control pin straps plus first access
// [RULE18] accepts parallel-port host as well as processor
// [RULE19] host straps unused pins per mode
// [RULE20] wait undriven until first handshake address strobe
// [RULE21] handshake host gates strobe with chip select; the host ties chip select low in handshake mode
// [RULE22] bus driven only during selected read; the code also drives line zero throughout spi mode
// [RULE23] write data taken at strobe closing edge
`timescale 1ns/1ps
module pport_device
   import pport_pkg::*;
#(
   parameter int RESET_CYCLES = 16
)(
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   input  wire logic              i_clk_en,
   pport_if.device                pins,
   input  wire logic [DATA_W-1:0] i_reg_rdata,
   input  wire logic              i_spi_miso,
   output logic      [ADDR_W-1:0] o_reg_addr,
   output logic                   o_reg_wr,
   output logic      [DATA_W-1:0] o_reg_wdata,
   output logic                   o_reg_rd,
   output mode_t                  o_mode,
   output logic                   o_ready,
   output logic                   o_osc_en,
   output logic                   o_spi_nss_n,
   output logic                   o_spi_sck,
   output logic                   o_spi_mosi
);
   localparam int CNT_W = $clog2(RESET_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RESET_CYCLES - 1);

   if (RESET_CYCLES < 1) begin : g_chk
      $error("RESET_CYCLES must be at least 1");
   end

   logic [PIN_W-1:0]  s1_q, s2_q, s3_q, st_q;
   dev_state_t        state_q, state_d;
   mode_t             mode_q, det_mode;
   logic [CNT_W-1:0]  cnt_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] rdata_q, wdata_q;
   logic              rd_q, wr_q, latch_prev_q, wait_en_q, wait_q, ded_open_q, miso_q;

   // pin synchroniser, a change counts once stages two and three agree
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
         st_q <= PIN_IDLE;
      end else if (i_clk_en) begin
         s1_q <= {pins.shared_addr_data_bus, pins.reset_powerdown_in, pins.chip_select_n, pins.wr_pin,
                  pins.strobe_pin_n, pins.addr_line_zero, pins.addr_line_one, pins.addr_line_two,
                  pins.latch_pin};
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= (s2_q & s3_q) | (st_q & (s2_q | s3_q));
      end
   end

   // named views of the filtered pins
   wire logic              pd    = st_q[P_RESET_POWERDOWN_IN];
   wire logic              latch = st_q[P_LATCH];
   wire logic [2:0]        aln   = {st_q[P_A2], st_q[P_A1], st_q[P_A0]};
   wire logic              cs    = ~st_q[P_CS];
   wire logic              strb  = ~st_q[P_STRB];
   wire logic              wrp   = st_q[P_WR];
   wire logic [DATA_W-1:0] bus   = st_q[P_BUS +: DATA_W];
   wire logic              run   = (state_q == ST_RUN);
   wire logic              cnt_done = (cnt_q == CNT_LAST);

   // mode classes
   wire logic is_sep = (mode_q == M_SEP_DED) | (mode_q == M_SEP_MUX);
   wire logic is_com = (mode_q == M_COM_DED) | (mode_q == M_COM_MUX);
   wire logic is_epp = (mode_q == M_EPP);
   wire logic is_spi = (mode_q == M_SPI);
   wire logic is_ded = (mode_q == M_SEP_DED) | (mode_q == M_COM_DED);

   // strap decode sampled in the detect state
   // [RULE17] [RULE18] strap detection, parallel port too
   always_comb begin
      det_mode = M_NONE;
      if (latch & cs & aln[2] & aln[1]) begin
         det_mode = M_EPP;
      end else if (latch & cs & ~aln[1] & ~strb & wrp) begin
         det_mode = M_SPI;
      end else if (latch) begin
         det_mode = M_SEP_DED;
      end else if (aln == STRAP_SEP_MUX) begin
         det_mode = M_SEP_MUX;
      end else if (aln == STRAP_COM_MUX) begin
         det_mode = M_COM_MUX;
      end
   end

   // access decode
   // [RULE1] separate strobes
   // [RULE2] common strobe, select line
   // [RULE3] handshake read and write
   // [RULE21] chip select gates the strobe
   wire logic rd_act = run & ((is_sep & cs & strb & wrp) | (is_com & cs & strb & wrp)
                            | (is_epp & wait_en_q & cs & strb & wrp));
   wire logic wr_act = run & ((is_sep & cs & ~wrp) | (is_com & cs & strb & ~wrp)
                            | (is_epp & wait_en_q & cs & strb & ~wrp));
   // [RULE17] first write tells common from separate strobes
   wire logic ded_is_com = run & ded_open_q & (mode_q == M_SEP_DED) & cs & strb & ~wrp;

   // address latch enable and source
   // [RULE5] latch enable high
   // [RULE6] address strobe high
   // [RULE7] handshake strobe low
   // [RULE9] dedicated lines to bits 0-2
   wire logic latch_en = run & ((is_ded & ~rd_act & ~wr_act)
                              | ((mode_q == M_SEP_MUX) & latch)
                              | ((mode_q == M_COM_MUX) & latch)
                              | (is_epp & ~latch));
   // [RULE4] low six lines carry the address
   wire logic [ADDR_W-1:0] latch_val = is_ded ? {{(ADDR_W-DED_W){1'b0}}, aln} : bus[ADDR_W-1:0];

   // [RULE14] [RULE15] [RULE16] power-down, reset phase, detection
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF:    if (!pd) state_d = ST_RESET;
         ST_RESET:  if (cnt_done) state_d = ST_DETECT;
         ST_DETECT: if (det_mode != M_NONE) state_d = ST_RUN;
         ST_RUN:    state_d = ST_RUN;
         default:   state_d = ST_OFF;
      endcase
      if (pd) begin
         state_d = ST_OFF;
      end
   end

   // state, reset-phase count and mode
   // [RULE16] mode cleared on each reset
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= ST_OFF;
         cnt_q   <= '0;
         mode_q  <= M_NONE;
      end else if (i_clk_en) begin
         state_q <= state_d;
         cnt_q   <= (state_q == ST_RESET) ? cnt_q + CNT_W'(1) : '0;
         if (state_q != ST_RUN) begin
            mode_q <= (state_q == ST_DETECT) ? det_mode : M_NONE;
         end else if (ded_is_com) begin
            mode_q <= M_COM_DED;
         end
      end
   end

   // access tracking and captured data
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         addr_q     <= '0;
         rdata_q    <= '0;
         wdata_q    <= '0;
         rd_q       <= 1'b0;
         wr_q       <= 1'b0;
         ded_open_q <= 1'b1;
         miso_q     <= 1'b0;
      end else if (i_clk_en) begin
         if (latch_en) addr_q <= latch_val;
         if (rd_act) rdata_q <= i_reg_rdata;
         // [RULE23] data held up to closing edge
         if (wr_act) wdata_q <= bus;
         rd_q       <= rd_act;
         wr_q       <= wr_act;
         ded_open_q <= run ? (ded_open_q & ~wr_act) : 1'b1;
         miso_q     <= i_spi_miso;
      end
   end

   // handshake wait, undriven until the first address strobe fall
   // [RULE20] enable on first strobe fall
   // [RULE8] wait follows the access
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         latch_prev_q <= 1'b1;
         wait_en_q    <= 1'b0;
         wait_q       <= 1'b0;
      end else if (i_clk_en) begin
         latch_prev_q <= latch;
         wait_en_q    <= run & is_epp & (wait_en_q | (latch_prev_q & ~latch));
         wait_q       <= run & is_epp & (~latch | (cs & strb));
      end
   end

   // register port
   // [RULE23] write pulse on closing edge
   assign o_reg_wr    = wr_q & ~wr_act;
   assign o_reg_rd    = rd_act & ~rd_q;
   assign o_reg_addr  = addr_q;
   assign o_reg_wdata = wdata_q;
   assign o_mode      = mode_q;
   assign o_ready     = run;
   // [RULE14] oscillator held off
   assign o_osc_en    = ~pd;

   // bus and wait drivers
   // [RULE10] [RULE11] [RULE22] drive only during selected read, except line zero always in spi mode
   // [RULE13] spi serial output on line zero
   assign pins.bus_dev_out = (run & is_spi) ? {{(DATA_W-1){1'b0}}, miso_q} : rdata_q;
   assign pins.bus_dev_oe  = (run & is_spi) ? SPI_OUT_MASK : {DATA_W{rd_act}};
   assign pins.a0_dev_out  = wait_q;    // high once the access may end
   assign pins.a0_dev_oe   = wait_en_q;

   // spi pin routing
   // [RULE12] select, clock and data in
   assign o_spi_nss_n = (run & is_spi) ? latch : 1'b1;
   assign o_spi_sck   = (run & is_spi) & aln[2];
   assign o_spi_mosi  = (run & is_spi) & aln[0];
endmodule // pport_device

// ### hw/pport_host.sv
`timescale 1ns/1ps
module pport_host
   import pport_pkg::*;
#(
   parameter int STROBE_CYCLES = 12,
   parameter int GAP_CYCLES    = 8
)(
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst,
   input  wire logic              i_clk_en,
   pport_if.host                  pins,
   input  wire mode_t             i_mode,
   input  wire logic              i_powerdown,
   input  wire logic              i_cmd_valid,
   input  wire logic              i_cmd_write,
   input  wire logic [ADDR_W-1:0] i_cmd_addr,
   input  wire logic [DATA_W-1:0] i_cmd_wdata,
   output logic                   o_cmd_ready,
   output logic      [DATA_W-1:0] o_rdata,
   output logic                   o_rdata_valid
);
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] STRB_LAST = CNT_W'(STROBE_CYCLES - 1);
   localparam logic [CNT_W-1:0] GAP_LAST  = CNT_W'(GAP_CYCLES - 1);

   if (STROBE_CYCLES < 10 || STROBE_CYCLES > 255 || GAP_CYCLES < 6 || GAP_CYCLES > 255) begin : g_chk
      $error("strobe must cover the device synchroniser delay");
   end

   host_state_t       state_q, state_d;
   logic [CNT_W-1:0]  cnt_q;
   logic [HS_W-1:0]   s1_q, s2_q, s3_q, st_q;
   logic              w_q, pd_q, rv_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q, rdata_q;

   // mode classes and phase conditions
   wire logic epp     = (i_mode == M_EPP);
   wire logic spi     = (i_mode == M_SPI);
   wire logic ded     = (i_mode == M_SEP_DED) | (i_mode == M_COM_DED);
   wire logic sep     = (i_mode == M_SEP_DED) | (i_mode == M_SEP_MUX);
   wire logic mux     = ~ded & ~spi & (i_mode != M_NONE);
   wire logic wait_hi = st_q[HS_WAIT];
   wire logic on_done = (cnt_q >= STRB_LAST) & (~epp | wait_hi);
   wire logic off_done = (cnt_q >= GAP_LAST) & (~epp | ~wait_hi);

   // command sequence, dedicated address settles before the strobe
   always_comb begin
      state_d = state_q;
      case (state_q)
         H_IDLE:     if (i_cmd_valid && (ded || mux)) state_d = ded ? H_ADDR_GAP : H_ADDR;
         H_ADDR:     if (on_done) state_d = H_ADDR_GAP;
         H_ADDR_GAP: if (off_done) state_d = H_STRB;
         H_STRB:     if (on_done) state_d = H_GAP;
         H_GAP:      if (off_done) state_d = H_IDLE;
         default:    state_d = H_IDLE;
      endcase
   end

   // sequencer and command hold
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= H_IDLE;
         cnt_q   <= '0;
         w_q     <= 1'b0;
         addr_q  <= '0;
         wdata_q <= '0;
         pd_q    <= 1'b1;
      end else if (i_clk_en) begin
         state_q <= state_d;
         cnt_q   <= (state_d != state_q) ? '0 : cnt_q + CNT_W'(1);
         pd_q    <= i_powerdown;
         if (o_cmd_ready && i_cmd_valid) begin
            w_q     <= i_cmd_write;
            addr_q  <= i_cmd_addr;
            wdata_q <= i_cmd_wdata;
         end
      end
   end

   // pin synchroniser and read capture
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_q    <= HS_IDLE;
         s2_q    <= HS_IDLE;
         s3_q    <= HS_IDLE;
         st_q    <= HS_IDLE;
         rdata_q <= '0;
         rv_q    <= 1'b0;
      end else if (i_clk_en) begin
         s1_q <= {pins.addr_line_zero, pins.shared_addr_data_bus};
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= (s2_q & s3_q) | (st_q & (s2_q | s3_q));
         rv_q <= (state_q == H_STRB) & on_done & ~w_q;
         if ((state_q == H_STRB) && on_done && !w_q) rdata_q <= st_q[DATA_W-1:0];
      end
   end

   // phase flags
   wire logic in_addr = (state_q == H_ADDR);
   wire logic addr_on = in_addr | (state_q == H_ADDR_GAP);
   wire logic in_strb = (state_q == H_STRB);
   wire logic cs_act  = addr_on | in_strb;

   // strap and strobe drivers per interface type
   // [RULE19] straps per mode
   assign pins.latch_pin     = (i_mode == M_SEP_MUX || i_mode == M_COM_MUX) ? in_addr : (epp ? ~in_addr : 1'b1);
   assign pins.addr_line_two = ded ? addr_q[2] : epp;
   assign pins.addr_line_one = ded ? addr_q[1] : mux;
   assign pins.a0_host_out   = ded ? addr_q[0] : STRAP_SEP_MUX[0] & (i_mode == M_SEP_MUX);
   assign pins.a0_host_oe    = ~epp;
   assign pins.strobe_pin_n  = sep ? ~(in_strb & ~w_q) : ~in_strb;
   assign pins.wr_pin        = ~(in_strb & w_q);
   // [RULE21] handshake select tied low
   assign pins.chip_select_n = (epp | spi) ? 1'b0 : ~cs_act;
   assign pins.reset_powerdown_in = pd_q;
   assign pins.bus_host_out  = addr_on ? {{(DATA_W-ADDR_W){1'b0}}, addr_q} : wdata_q;
   assign pins.bus_host_oe   = {DATA_W{(mux & addr_on) | (in_strb & w_q)}};

   // user side
   assign o_cmd_ready   = (state_q == H_IDLE) & (ded | mux);
   assign o_rdata       = rdata_q;
   assign o_rdata_valid = rv_q;
endmodule // pport_host

// ### hw/pport_if.sv
`timescale 1ns/1ps
interface pport_if;
   import pport_pkg::*;
   logic              latch_pin;       // address latch / strobe / slave select
   logic              addr_line_two;
   logic              addr_line_one;
   logic              a0_host_out;
   logic              a0_host_oe;
   logic              a0_dev_out;      // handshake_wait_n
   logic              a0_dev_oe;
   logic              addr_line_zero;
   logic              strobe_pin_n;    // read or data strobe
   logic              wr_pin;          // write strobe, read/write select
   logic              chip_select_n;
   logic              reset_powerdown_in;
   logic [DATA_W-1:0] bus_host_out;
   logic [DATA_W-1:0] bus_host_oe;
   logic [DATA_W-1:0] bus_dev_out;
   logic [DATA_W-1:0] bus_dev_oe;
   logic [DATA_W-1:0] shared_addr_data_bus;

   // wire resolution, undriven lines pulled high
   assign addr_line_zero = a0_dev_oe ? a0_dev_out : (a0_host_oe ? a0_host_out : PULL_LEVEL);
   assign shared_addr_data_bus = (bus_dev_oe & bus_dev_out)
                               | (~bus_dev_oe & bus_host_oe & bus_host_out)
                               | (~bus_dev_oe & ~bus_host_oe & {DATA_W{PULL_LEVEL}});

   modport device (
      input  latch_pin, addr_line_two, addr_line_one, addr_line_zero, strobe_pin_n, wr_pin,
      input  chip_select_n, reset_powerdown_in, shared_addr_data_bus,
      output a0_dev_out, a0_dev_oe, bus_dev_out, bus_dev_oe
   );
   modport host (
      output latch_pin, addr_line_two, addr_line_one, a0_host_out, a0_host_oe, strobe_pin_n, wr_pin,
      output chip_select_n, reset_powerdown_in, bus_host_out, bus_host_oe,
      input  addr_line_zero, shared_addr_data_bus
   );
endinterface

// ### hw/pport_pkg.sv
package pport_pkg;
   // bus widths
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int DED_W  = 3;

   // positions in the device's synchronised pin vector
   localparam int P_LATCH = 0;
   localparam int P_A2    = 1;
   localparam int P_A1    = 2;
   localparam int P_A0    = 3;
   localparam int P_STRB  = 4;
   localparam int P_WR    = 5;
   localparam int P_CS    = 6;
   localparam int P_RESET_POWERDOWN_IN = 7;
   localparam int P_BUS   = 8;
   localparam int PIN_W   = P_BUS + DATA_W;
   localparam logic [PIN_W-1:0] PIN_IDLE = 16'hFFFF;

   // host-side synchronised vector: bus in low bits, wait on top
   localparam int HS_W    = DATA_W + 1;
   localparam int HS_WAIT = DATA_W;
   localparam logic [HS_W-1:0] HS_IDLE = 9'h1FF;

   // level an undriven two-way line settles to
   localparam logic PULL_LEVEL = 1'b1;
   // strap patterns on address lines 2..0
   localparam logic [2:0] STRAP_SEP_MUX = 3'h3;
   localparam logic [2:0] STRAP_COM_MUX = 3'h2;
   localparam logic [DATA_W-1:0] SPI_OUT_MASK = 8'h01;

   typedef enum logic [2:0] {
      M_NONE    = 3'h0,
      M_SEP_DED = 3'h1,
      M_COM_DED = 3'h3,
      M_SEP_MUX = 3'h2,
      M_COM_MUX = 3'h6,
      M_EPP     = 3'h7,
      M_SPI     = 3'h5
   } mode_t;

   typedef enum logic [1:0] {
      ST_OFF    = 2'h0,
      ST_RESET  = 2'h1,
      ST_DETECT = 2'h3,
      ST_RUN    = 2'h2
   } dev_state_t;

   typedef enum logic [2:0] {
      H_IDLE     = 3'h0,
      H_ADDR     = 3'h1,
      H_ADDR_GAP = 3'h3,
      H_STRB     = 3'h2,
      H_GAP      = 3'h6
   } host_state_t;
endpackage

// ### tb/host_parallel_port_autodetect_tb.sv
`timescale 1ns/1ps
module host_parallel_port_autodetect_tb;
   import pport_pkg::*;
   localparam int RST_CYC = 4;
   logic              i_sys_clk;
   logic              i_rst;
   mode_t             host_mode;
   mode_t             dev_mode;
   logic              powerdown;
   logic              cmd_valid;
   logic              cmd_write;
   logic [ADDR_W-1:0] cmd_addr;
   logic [DATA_W-1:0] cmd_wdata;
   logic              cmd_ready;
   logic [DATA_W-1:0] rdata;
   logic              rdata_valid;
   logic [ADDR_W-1:0] reg_addr;
   logic              reg_wr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic              ready;
   logic              osc_en;
   logic              spi_miso;
   logic              spi_nss_n;
   logic              spi_sck;
   logic              spi_mosi;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_mem [64];
   int                n_mismatch;
   int                cmp_count;
   int                cycles;

   pport_if link ();

   pport_device #(.RESET_CYCLES(RST_CYC)) pport_device_i (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(1'b1), .pins(link), .i_reg_rdata(reg_rdata),
      .i_spi_miso(spi_miso), .o_reg_addr(reg_addr), .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd),
      .o_mode(dev_mode), .o_ready(ready), .o_osc_en(osc_en), .o_spi_nss_n(spi_nss_n), .o_spi_sck(spi_sck),
      .o_spi_mosi(spi_mosi)
   );

   pport_host #(.STROBE_CYCLES(10), .GAP_CYCLES(6)) pport_host_i (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(1'b1), .pins(link), .i_mode(host_mode),
      .i_powerdown(powerdown), .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
      .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready), .o_rdata(rdata), .o_rdata_valid(rdata_valid)
   );

   pport_link_props pport_link_props_i (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .latch_pin(link.latch_pin), .addr_line_two(link.addr_line_two),
      .addr_line_one(link.addr_line_one), .a0_dev_out(link.a0_dev_out), .a0_dev_oe(link.a0_dev_oe),
      .strobe_pin_n(link.strobe_pin_n), .wr_pin(link.wr_pin), .chip_select_n(link.chip_select_n),
      .reset_powerdown_in(link.reset_powerdown_in), .bus_host_oe(link.bus_host_oe), .bus_dev_oe(link.bus_dev_oe)
   );

   // register file behind the device
   assign reg_rdata = reg_mem[reg_addr];
   always @(posedge i_sys_clk) begin
      if (reg_wr === 1'b1) begin
         reg_mem[reg_addr] <= reg_wdata;
      end
   end

   // clock, and a hang guard
   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_mode(input mode_t got, input mode_t exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // wait n edges, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask

   // powerdown pulse, new straps, then detection
   task automatic enter_mode(input mode_t m);
      powerdown = 1'b1;
      tick(20);
      check_byte({7'h0, osc_en}, 8'h00);
      check_mode(dev_mode, M_NONE);
      host_mode = m;
      tick(4);
      powerdown = 1'b0;
      tick(RST_CYC + 30);
      check_byte({6'h0, osc_en, ready}, 8'h03);
   endtask

   // one host access; dedicated mode keeps only three address bits
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         input logic ded);
      int k;
      logic seen;
      logic rd_seen;
      logic [ADDR_W-1:0] ea;
      ea = ded ? {3'h0, a[2:0]} : a;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 400) begin
         tick(1);
         k++;
      end
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = a;
      cmd_wdata = d;
      tick(1);
      cmd_valid = 1'b0;
      k = 0;
      seen = 1'b0;
      rd_seen = 1'b0;
      while (!seen && k < 400) begin
         seen = wr ? (reg_wr === 1'b1) : (rdata_valid === 1'b1);
         rd_seen = rd_seen | (reg_rd === 1'b1);
         if (!seen) begin
            tick(1);
         end
         k++;
      end
      check_byte({7'h0, seen}, 8'h01);
      check_byte({7'h0, rd_seen}, {7'h0, ~wr});
      check_byte({2'h0, reg_addr}, {2'h0, ea});
      check_byte(wr ? reg_wdata : rdata, d);
   endtask

   task automatic t_mux(input mode_t m);
      enter_mode(m);
      check_mode(dev_mode, m);
      access(1'b1, 6'h3F, 8'hA5, 1'b0);
      access(1'b0, 6'h3F, 8'hA5, 1'b0);
      access(1'b1, 6'h00, 8'h5A, 1'b0);
      access(1'b0, 6'h00, 8'h5A, 1'b0);
   endtask

   task automatic t_ded(input mode_t m);
      enter_mode(m);
      check_mode(dev_mode, M_SEP_DED);
      access(1'b1, 6'h2D, 8'hC3, 1'b1);
      check_mode(dev_mode, m);
      access(1'b0, 6'h05, 8'hC3, 1'b1);
      access(1'b1, 6'h02, 8'h81, 1'b1);
      access(1'b0, 6'h3A, 8'h81, 1'b1);
   endtask

   task automatic t_epp();
      enter_mode(M_EPP);
      check_mode(dev_mode, M_EPP);
      check_byte({7'h0, link.a0_dev_oe}, 8'h00);
      access(1'b1, 6'h2A, 8'h3C, 1'b0);
      access(1'b0, 6'h2A, 8'h3C, 1'b0);
      tick(10);
      check_byte({6'h0, link.a0_dev_oe, link.addr_line_zero}, 8'h02);
   endtask

   task automatic t_spi();
      enter_mode(M_SPI);
      check_mode(dev_mode, M_SPI);
      check_byte({7'h0, cmd_ready}, 8'h00);
      check_byte({5'h0, spi_nss_n, spi_sck, spi_mosi}, 8'h04);
      spi_miso = 1'b1;
      tick(3);
      check_byte({7'h0, link.shared_addr_data_bus[0]}, 8'h01);
      spi_miso = 1'b0;
      tick(3);
      check_byte({7'h0, link.shared_addr_data_bus[0]}, 8'h00);
   endtask

   // main sequence
   initial begin
      i_rst = 1'b1;
      powerdown = 1'b1;
      host_mode = M_NONE;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = 6'h00;
      cmd_wdata = 8'h00;
      spi_miso = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (5) @(posedge i_sys_clk);
      #1;
      i_rst = 1'b0;
      tick(2);
      check_mode(dev_mode, M_NONE);
      check_byte(link.bus_dev_oe, 8'h00);
      t_mux(M_SEP_MUX);
      t_mux(M_COM_MUX);
      t_ded(M_SEP_DED);
      t_ded(M_COM_DED);
      t_epp();
      t_spi();
      finish_test();
   end
endmodule // host_parallel_port_autodetect_tb

// ### tb/pport_link_props.sv
`timescale 1ns/1ps
module pport_link_props
   import pport_pkg::*;
(
   input wire logic              i_sys_clk,
   input wire logic              i_rst,
   input wire logic              latch_pin,
   input wire logic              addr_line_two,
   input wire logic              addr_line_one,
   input wire logic              a0_dev_out,
   input wire logic              a0_dev_oe,
   input wire logic              strobe_pin_n,
   input wire logic              wr_pin,
   input wire logic              chip_select_n,
   input wire logic              reset_powerdown_in,
   input wire logic [DATA_W-1:0] bus_host_oe,
   input wire logic [DATA_W-1:0] bus_dev_oe
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   // pins released once powerdown has settled
   property p_pd_quiet;
      reset_powerdown_in [*8] |-> (bus_dev_oe == '0) && !a0_dev_oe;
   endproperty
   a_pd_quiet: assert property (p_pd_quiet)
      else $error("device drives pins in powerdown");

   // upper data lines only start driving inside a selected read
   property p_read_drive;
      $rose(|bus_dev_oe[7:1]) |-> !chip_select_n && !strobe_pin_n && wr_pin;
   endproperty
   a_read_drive: assert property (p_read_drive)
      else $error("data bus driven outside a read");

   // never both ends on the bus
   property p_no_fight;
      (|bus_dev_oe) |-> (bus_host_oe == '0);
   endproperty
   a_no_fight: assert property (p_no_fight)
      else $error("bus contention");

   // wait line only driven with handshake straps
   property p_wait_strap;
      (!reset_powerdown_in) [*8] ##0 a0_dev_oe |-> addr_line_two && addr_line_one;
   endproperty
   a_wait_strap: assert property (p_wait_strap)
      else $error("wait driven without handshake straps");

   // handshake host keeps chip select low
   property p_epp_cs;
      (!reset_powerdown_in) [*8] ##0 a0_dev_oe |-> !chip_select_n;
   endproperty
   a_epp_cs: assert property (p_epp_cs)
      else $error("chip select high in handshake mode");

   // wait output enabled inside an address strobe
   property p_wait_first;
      $rose(a0_dev_oe) |-> !latch_pin;
   endproperty
   a_wait_first: assert property (p_wait_first)
      else $error("wait enabled without address strobe");

   // wait goes high to end the access
   property p_wait_end;
      a0_dev_oe && $fell(strobe_pin_n) |-> ##[1:8] a0_dev_out;
   endproperty
   a_wait_end: assert property (p_wait_end)
      else $error("wait did not end access");

   // wait returns low after strobe release
   property p_wait_ready;
      a0_dev_oe && $rose(strobe_pin_n) |-> ##[1:8] !a0_dev_out;
   endproperty
   a_wait_ready: assert property (p_wait_ready)
      else $error("wait did not return low");

   // host strobe_pin_n pulses are long enough for the pin filter
   property p_strobe_width;
      $fell(strobe_pin_n) |-> !strobe_pin_n [*8];
   endproperty
   a_strobe_width: assert property (p_strobe_width)
      else $error("strobe too short");
endmodule // pport_link_props
